// ==== hdl/eiu_map.vh ====
// Purpose : Register offsets, field positions and reset values for the
//           external pin interrupt unit.
// Assumes : 3-bit word address, 8-bit data.
// Notes   : Definitions only.
`ifndef EIU_MAP_VH
`define EIU_MAP_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define EIU_ADDR_W          3
`define EIU_OFS_MCU_CTRL    3'h0
`define EIU_OFS_EXT_CTRL    3'h1
`define EIU_OFS_ENABLE      3'h2
`define EIU_OFS_FLAGS       3'h3
`define EIU_OFS_MASK_LO     3'h4
`define EIU_OFS_MASK_HI     3'h5
`define EIU_OFS_PIN_STATE   3'h6

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define EIU_L1_SENSE_HI     3
`define EIU_L1_SENSE_LO     2
`define EIU_L0_SENSE_HI     1
`define EIU_L0_SENSE_LO     0
`define EIU_L2_EDGE_SEL     0
// Enable and flag registers share this layout
`define EIU_BIT_L1          7
`define EIU_BIT_L0          6
`define EIU_BIT_L2          5
`define EIU_BIT_PC_HI       4
`define EIU_BIT_PC_LO       3
// Request vector index order
`define EIU_REQ_L0          0
`define EIU_REQ_L1          1
`define EIU_REQ_L2          2
`define EIU_REQ_PC_LO       3
`define EIU_REQ_PC_HI       4

// ----------------------------------------------------------------------
// Sense codes and reset values
// ----------------------------------------------------------------------
`define EIU_SENSE_LOW       2'h0
`define EIU_SENSE_ANY       2'h1
`define EIU_SENSE_FALL      2'h2
`define EIU_SENSE_RISE      2'h3
`define EIU_RST_BYTE        8'h00
`define EIU_LVL_SAMPLES     2'h2

`endif

// ==== hdl/eiu_sync.v ====
// Purpose : Two flip-flop level synchroniser, WIDTH bits wide.
// Assumes : Inputs may change at any time.
// Notes   : First stage is read only by the second stage.
`timescale 1ns/100ps

module eiu_sync #(
	parameter WIDTH = 1
) (
	input  wire             mclk_in,
	input  wire             rst_b_in,
	input  wire [WIDTH-1:0] d_in,
	output wire [WIDTH-1:0] q_out
);

	reg [WIDTH-1:0] meta_r;
	reg [WIDTH-1:0] stab_r;

	// Two stage capture, reset to zero
	always @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			meta_r <= {WIDTH{1'b0}};
			stab_r <= {WIDTH{1'b0}};
		end else begin
			meta_r <= d_in;
			stab_r <= meta_r;
		end
	end

	assign q_out = stab_r;

endmodule // eiu_sync

// ==== hdl/eiu_top.v ====
// Purpose : External pin interrupt unit: three dedicated interrupt lines,
//           sixteen pin-change inputs, sleep wake-up logic.
// Assumes : Register port with read data one cycle after the read strobe.
// Notes   : Pins are read whatever their direction in the port block.
//
// Functional notes
// - Requests come from three dedicated lines and sixteen pin-change inputs.
// - Enabled interrupts still fire when their pin is an output.
// - Lines zero and one: fall, rise, low level; line two: edges only.
// - Level mode on lines zero/one requests while the pin stays low.
// - High pin-change group fires on any toggle of enabled inputs 15..8.
// - Low pin-change group fires on any toggle of enabled inputs 7..0.
// - Two per-group masks select contributing inputs; masked ones are ignored.
// - Edges on lines zero/one are seen only while the I/O clock runs.
// - Level, line-two edge and pin-change detection need no I/O clock.
// - I/O clock stops in every sleep mode but Idle.
// - Power-down level wake needs two watchdog-clock samples of the level.
// - Wake if level passes sampling or is held until start-up ends.
// - Level gone before start-up end: wake, but no level interrupt.
// - Start-up time comes from clock-system settings, not this unit.
// - Sense choice comes from fields in the two MCU control registers.
// - Lines zero/one code: 00 low, 01 any change, 10 fall, 11 rise.
// - Line two sense bit: 0 falling edge, 1 rising edge.
// - Edge sets flag; handler entry or write-one clears; zero in level mode.
// - Edge modes sample the pin first; pulses over one clock are caught.
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`include "eiu_map.vh"

module eiu_top (
	input  wire        mclk_in,
	input  wire        rst_b_in,
	// Register port
	input  wire [2:0]  reg_addr_in,
	input  wire [7:0]  reg_wdata_in,
	input  wire        reg_wr_in,
	input  wire        reg_rd_in,
	output reg  [7:0]  reg_rdata_out,
	// Pins
	input  wire        ext_irq_line_zero_in,
	input  wire        ext_irq_line_one_in,
	input  wire        ext_irq_line_two_in,
	input  wire [15:0] pin_change_inputs_in,
	// Processor side
	input  wire [4:0]  irq_ack_in,
	output wire [4:0]  irq_req_out,
	// Sleep controller side
	input  wire        sleep_in,
	input  wire        idle_mode_in,
	input  wire        power_down_in,
	input  wire        wdt_tick_in,
	input  wire        startup_done_in,
	output wire        wake_out,
	output wire        io_clk_run_out
);

	// ------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------

	// Edge hit for a two-bit sense code; level mode gives no edge
	function edge_hit;
		input [1:0] code;
		input       cur;
		input       prev;
		begin
			case (code)
			`EIU_SENSE_ANY:  edge_hit = cur ^ prev;
			`EIU_SENSE_FALL: edge_hit = prev & ~cur;
			`EIU_SENSE_RISE: edge_hit = cur & ~prev;
			default:         edge_hit = 1'b0;
			endcase
		end
	endfunction

	// Enable/flag byte layout into request order
	function [4:0] byte_to_src;
		input [7:0] b;
		begin
			byte_to_src[`EIU_REQ_L0]    = b[`EIU_BIT_L0];
			byte_to_src[`EIU_REQ_L1]    = b[`EIU_BIT_L1];
			byte_to_src[`EIU_REQ_L2]    = b[`EIU_BIT_L2];
			byte_to_src[`EIU_REQ_PC_LO] = b[`EIU_BIT_PC_LO];
			byte_to_src[`EIU_REQ_PC_HI] = b[`EIU_BIT_PC_HI];
		end
	endfunction

	// Request order back into the byte layout, spare bits zero
	function [7:0] src_to_byte;
		input [4:0] s;
		begin
			src_to_byte                 = 8'h00;
			src_to_byte[`EIU_BIT_L0]    = s[`EIU_REQ_L0];
			src_to_byte[`EIU_BIT_L1]    = s[`EIU_REQ_L1];
			src_to_byte[`EIU_BIT_L2]    = s[`EIU_REQ_L2];
			src_to_byte[`EIU_BIT_PC_LO] = s[`EIU_REQ_PC_LO];
			src_to_byte[`EIU_BIT_PC_HI] = s[`EIU_REQ_PC_HI];
		end
	endfunction

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	localparam LW_IDLE = 2'h0;
	localparam LW_ONE  = 2'h1;
	localparam LW_WAKE = 2'h2;

	reg  [3:0]  mcu_control_reg_r;
	reg         extended_mcu_control_reg_r;
	reg  [4:0]  enable_r;
	reg  [4:0]  flag_r;
	reg  [4:0]  flag_nxt;
	reg  [7:0]  pin_change_mask_low_group_r;
	reg  [7:0]  pin_change_mask_high_group_r;
	reg  [2:0]  line_prev_r;
	reg  [15:0] pc_prev_r;
	reg  [1:0]  lw_state_r;
	reg  [1:0]  lw_state_nxt;
	reg  [7:0]  rdata_nxt;
	reg  [2:0]  warm_r;

	wire [18:0] pins_sync;
	wire [2:0]  line_sync;
	wire [15:0] pc_sync;
	wire [1:0]  line_zero_sense;
	wire [1:0]  line_one_sense;
	wire        line_two_edge_select;
	wire        io_clk_run;
	wire [4:0]  evt;
	wire [4:0]  wr_clr;
	wire [1:0]  level_mode;
	wire [1:0]  level_req;
	wire        level_any;
	wire [4:0]  req;
	wire        wr_hit;
	wire        hist_ok;

	// ------------------------------------------------------------------
	// Pin synchronisation
	// ------------------------------------------------------------------

	// Pins read regardless of port direction
	eiu_sync #(
		.WIDTH (19)
	) u_sync (
		.mclk_in  (mclk_in),
		.rst_b_in (rst_b_in),
		.d_in     ({pin_change_inputs_in, ext_irq_line_two_in,
			ext_irq_line_one_in, ext_irq_line_zero_in}),
		.q_out    (pins_sync)
	);

	assign line_sync = pins_sync[2:0];
	assign pc_sync   = pins_sync[18:3];

	// ------------------------------------------------------------------
	// Configuration fields
	// ------------------------------------------------------------------

	// Sense fields from the two control registers
	assign line_zero_sense = {mcu_control_reg_r[`EIU_L0_SENSE_HI],
		mcu_control_reg_r[`EIU_L0_SENSE_LO]};
	assign line_one_sense  = {mcu_control_reg_r[`EIU_L1_SENSE_HI],
		mcu_control_reg_r[`EIU_L1_SENSE_LO]};
	assign line_two_edge_select = extended_mcu_control_reg_r;

	// I/O clock runs awake or in Idle only
	assign io_clk_run     = ~sleep_in | idle_mode_in;
	assign io_clk_run_out = io_clk_run;

	assign level_mode[0] = (line_zero_sense == `EIU_SENSE_LOW);
	assign level_mode[1] = (line_one_sense == `EIU_SENSE_LOW);

	// ------------------------------------------------------------------
	// Event detection
	// ------------------------------------------------------------------

	// Sample history for edge detection
	always @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			line_prev_r <= 3'h0;
			pc_prev_r   <= 16'h0000;
		end else begin
			line_prev_r <= line_sync;
			pc_prev_r   <= pc_sync;
		end
	end

	// History warm-up after reset
	// Synchroniser leaves reset at zero while idle pins sit high;
	// without this the first samples would read as edges
	always @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			warm_r <= 3'h0;
		else
			warm_r <= {warm_r[1:0], 1'b1};
	end

	assign hist_ok = warm_r[2];

	// Lines zero/one edges need the I/O clock
	assign evt[`EIU_REQ_L0] = io_clk_run &
		edge_hit(line_zero_sense, line_sync[0], line_prev_r[0]);
	assign evt[`EIU_REQ_L1] = io_clk_run &
		edge_hit(line_one_sense, line_sync[1], line_prev_r[1]);

	// Line two: edge only, independent of the I/O clock
	assign evt[`EIU_REQ_L2] = line_two_edge_select ?
		(line_sync[2] & ~line_prev_r[2]) :
		(line_prev_r[2] & ~line_sync[2]);

	// Pin-change groups, masked per input
	assign evt[`EIU_REQ_PC_LO] = |((pc_sync[7:0] ^ pc_prev_r[7:0]) &
		pin_change_mask_low_group_r);
	assign evt[`EIU_REQ_PC_HI] = |((pc_sync[15:8] ^ pc_prev_r[15:8]) &
		pin_change_mask_high_group_r);

	// ------------------------------------------------------------------
	// Flags
	// ------------------------------------------------------------------
	assign wr_hit = reg_wr_in & (reg_addr_in == `EIU_OFS_FLAGS);
	assign wr_clr = wr_hit ? byte_to_src(reg_wdata_in) : 5'h00;

	// Set beats clear; level mode holds flag low
	always @* begin
		flag_nxt = (flag_r & ~(wr_clr | irq_ack_in)) |
			(evt & {5{hist_ok}});
		if (level_mode[0])
			flag_nxt[`EIU_REQ_L0] = 1'b0;
		if (level_mode[1])
			flag_nxt[`EIU_REQ_L1] = 1'b0;
	end

	always @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			flag_r <= 5'h00;
		else
			flag_r <= flag_nxt;
	end

	// ------------------------------------------------------------------
	// Requests to the processor
	// ------------------------------------------------------------------

	// Low level requests while the pin is low
	assign level_req[0] = level_mode[0] & ~line_sync[0] &
		enable_r[`EIU_REQ_L0];
	assign level_req[1] = level_mode[1] & ~line_sync[1] &
		enable_r[`EIU_REQ_L1];
	assign level_any = |level_req;

	// Live level means a lost level gives no request
	assign req = (flag_r & enable_r) | {3'h0, level_req};
	assign irq_req_out = req;

	// ------------------------------------------------------------------
	// Power-down level wake qualifier
	// ------------------------------------------------------------------

	// Two watchdog samples of the level, then hold wake to start-up end
	always @* begin
		lw_state_nxt = lw_state_r;
		case (lw_state_r)
		LW_IDLE: begin
			if (power_down_in & wdt_tick_in & level_any)
				lw_state_nxt = LW_ONE;
		end
		LW_ONE: begin
			if (!power_down_in)
				lw_state_nxt = LW_IDLE;
			else if (wdt_tick_in)
				lw_state_nxt = level_any ? LW_WAKE : LW_IDLE;
		end
		LW_WAKE: begin
			// Start-up length set by clock system
			if (startup_done_in)
				lw_state_nxt = LW_IDLE;
		end
		default: lw_state_nxt = LW_IDLE;
		endcase
	end

	always @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			lw_state_r <= LW_IDLE;
		else
			lw_state_r <= lw_state_nxt;
	end

	// Wake sources per sleep mode
	assign wake_out = sleep_in & ((lw_state_r == LW_WAKE) |
		(~power_down_in & level_any) |
		(|(req & {3'h7, 2'h0})) |
		(io_clk_run & (|req)));

	// ------------------------------------------------------------------
	// Register write
	// ------------------------------------------------------------------
	always @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			mcu_control_reg_r            <= 4'h0;
			extended_mcu_control_reg_r   <= 1'b0;
			enable_r                     <= 5'h00;
			pin_change_mask_low_group_r  <= `EIU_RST_BYTE;
			pin_change_mask_high_group_r <= `EIU_RST_BYTE;
		end else if (reg_wr_in) begin
			case (reg_addr_in)
			`EIU_OFS_MCU_CTRL: mcu_control_reg_r <= reg_wdata_in[3:0];
			`EIU_OFS_EXT_CTRL:
				extended_mcu_control_reg_r <=
					reg_wdata_in[`EIU_L2_EDGE_SEL];
			`EIU_OFS_ENABLE: enable_r <= byte_to_src(reg_wdata_in);
			`EIU_OFS_MASK_LO: pin_change_mask_low_group_r <= reg_wdata_in;
			`EIU_OFS_MASK_HI: pin_change_mask_high_group_r <= reg_wdata_in;
			default: ;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Register read
	// ------------------------------------------------------------------
	always @* begin
		rdata_nxt = 8'h00;
		case (reg_addr_in)
		`EIU_OFS_MCU_CTRL: rdata_nxt = {4'h0, mcu_control_reg_r};
		`EIU_OFS_EXT_CTRL: rdata_nxt = {7'h00, extended_mcu_control_reg_r};
		`EIU_OFS_ENABLE: rdata_nxt = src_to_byte(enable_r);
		`EIU_OFS_FLAGS:  rdata_nxt = src_to_byte(flag_r);
		`EIU_OFS_MASK_LO: rdata_nxt = pin_change_mask_low_group_r;
		`EIU_OFS_MASK_HI: rdata_nxt = pin_change_mask_high_group_r;
		`EIU_OFS_PIN_STATE: rdata_nxt = {5'h00, line_sync};
		default: rdata_nxt = 8'h00;
		endcase
	end

	// Read data stands one cycle after the strobe, else zero
	always @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			reg_rdata_out <= 8'h00;
		else if (reg_rd_in)
			reg_rdata_out <= rdata_nxt;
		else
			reg_rdata_out <= 8'h00;
	end

endmodule // eiu_top

// ==== tb/eiu_pins_model.sv ====
// Purpose : Off-chip drivers of the dedicated lines and pin-change pins.
// Assumes : Pins move only just after a rising clock edge.
// Notes   : Tasks are called from the bench by hierarchical name.
`timescale 1ns/100ps

module eiu_pins_model (
	input  wire        mclk_in,
	output wire        line_zero_out,
	output wire        line_one_out,
	output wire        line_two_out,
	output wire [15:0] pc_out
);
	reg [2:0]  line_r = 3'h7;
	reg [15:0] pc_r   = 16'h0000;

	// Levels reach the unit whatever the pin direction
	assign line_zero_out = line_r[0];
	assign line_one_out  = line_r[1];
	assign line_two_out  = line_r[2];
	assign pc_out        = pc_r;

	// Set one line, then hold it n cycles
	task drive_line(input integer idx, input reg v, input integer n);
		begin
			@(posedge mclk_in);
			line_r[idx] <= v;
			repeat (n) @(posedge mclk_in);
			#1;
		end
	endtask

	// Toggle one pin-change input, then hold it n cycles
	task toggle_pc(input integer idx, input integer n);
		begin
			@(posedge mclk_in);
			pc_r[idx] <= ~pc_r[idx];
			repeat (n) @(posedge mclk_in);
			#1;
		end
	endtask
endmodule // eiu_pins_model

// ==== tb/eiu_top_asserts.sv ====
// Purpose : Port-level relations of the external pin interrupt unit.
// Assumes : One clock, asynchronous active-low reset.
// Notes   : Bound into eiu_top.
`timescale 1ns/100ps

module eiu_top_asserts (
	input wire        mclk_in,
	input wire        rst_b_in,
	input wire        reg_wr_in,
	input wire        reg_rd_in,
	input wire [7:0]  reg_rdata_out,
	input wire        ext_irq_line_zero_in,
	input wire        ext_irq_line_two_in,
	input wire [15:0] pin_change_inputs_in,
	input wire [4:0]  irq_ack_in,
	input wire [4:0]  irq_req_out,
	input wire        sleep_in,
	input wire        idle_mode_in,
	input wire        io_clk_run_out,
	input wire        wake_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_b_in);

	// Clock run flag, read slot, request causes and holding
	property p_io_clk;
		io_clk_run_out == (!sleep_in || idle_mode_in);
	endproperty
	a_io_clk: assert property (p_io_clk) else $error("io clock flag wrong");
	property p_rd_idle;
		!reg_rd_in |=> reg_rdata_out == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
	property p_pc_lo;
		$rose(irq_req_out[3]) && !$past(reg_wr_in) |->
		$past(pin_change_inputs_in[7:0], 3) != $past(pin_change_inputs_in[7:0], 4);
	endproperty
	a_pc_lo: assert property (p_pc_lo) else $error("low group without toggle");
	property p_pc_hi;
		$rose(irq_req_out[4]) && !$past(reg_wr_in) |->
		$past(pin_change_inputs_in[15:8], 3) != $past(pin_change_inputs_in[15:8], 4);
	endproperty
	a_pc_hi: assert property (p_pc_hi) else $error("high group without toggle");
	property p_l2;
		$rose(irq_req_out[2]) && !$past(reg_wr_in) |->
		$past(ext_irq_line_two_in, 3) != $past(ext_irq_line_two_in, 4);
	endproperty
	a_l2: assert property (p_l2) else $error("line two without edge");
	property p_l0;
		$rose(irq_req_out[0]) && !$past(reg_wr_in) |->
		$past(ext_irq_line_zero_in, 3) != $past(ext_irq_line_zero_in, 4) ||
		$past(ext_irq_line_zero_in, 2) != $past(ext_irq_line_zero_in, 3);
	endproperty
	a_l0: assert property (p_l0) else $error("line zero without cause");
	property p_l2_ack;
		irq_ack_in[2] && !reg_wr_in &&
		$past(ext_irq_line_two_in, 1) == $past(ext_irq_line_two_in, 2) &&
		$past(ext_irq_line_two_in, 2) == $past(ext_irq_line_two_in, 3)
		|=> !irq_req_out[2];
	endproperty
	a_l2_ack: assert property (p_l2_ack) else $error("ack left line two");
	property p_pc_hold;
		irq_req_out[3] && !irq_ack_in[3] && !reg_wr_in |=> irq_req_out[3];
	endproperty
	a_pc_hold: assert property (p_pc_hold) else $error("low group dropped");

	c_pc: cover property (irq_req_out[3]);
	c_wake: cover property ($rose(wake_out));
	c_ack: cover property (irq_ack_in[2] && irq_req_out[2]);
endmodule // eiu_top_asserts

bind eiu_top eiu_top_asserts u_eiu_top_asserts (.mclk_in, .rst_b_in,
	.reg_wr_in, .reg_rd_in, .reg_rdata_out, .ext_irq_line_zero_in,
	.ext_irq_line_two_in, .pin_change_inputs_in, .irq_ack_in, .irq_req_out,
	.sleep_in, .idle_mode_in, .io_clk_run_out, .wake_out);

// ==== tb/eiu_top_tb.sv ====
// Purpose : Self-checking bench of the external pin interrupt unit.
// Assumes : 25 MHz clock, reset held 8 cycles.
// Notes   : Pins come from eiu_pins_model.
`timescale 1ns/100ps
`include "eiu_map.vh"

module eiu_top_tb;
	reg        mclk_in = 1'b0;
	reg        rst_b_in = 1'b0;
	reg [2:0]  reg_addr_in = 3'h0;
	reg [7:0]  reg_wdata_in = 8'h00;
	reg        reg_wr_in = 1'b0;
	reg        reg_rd_in = 1'b0;
	reg [4:0]  irq_ack_in = 5'h00;
	reg        sleep_in = 1'b0;
	reg        idle_mode_in = 1'b0;
	reg        power_down_in = 1'b0;
	reg [1:0]  strobe_r = 2'h0;
	reg [7:0]  en;
	wire [7:0] reg_rdata_out;
	wire [4:0] irq_req_out;
	wire       wake_out;
	wire       io_clk_run_out;
	wire       l0, l1, l2;
	wire [15:0] pcw;
	integer    failures = 0;
	integer    total_checks = 0;
	integer    cycles = 0;
	integer    l, c, v;

	always #20 mclk_in = ~mclk_in;

	eiu_pins_model u_eiu_pins_model (.mclk_in(mclk_in), .line_zero_out(l0),
		.line_one_out(l1), .line_two_out(l2), .pc_out(pcw));
	eiu_top u_eiu_top (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
		.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out), .ext_irq_line_zero_in(l0),
		.ext_irq_line_one_in(l1), .ext_irq_line_two_in(l2),
		.pin_change_inputs_in(pcw), .irq_ack_in(irq_ack_in),
		.irq_req_out(irq_req_out), .sleep_in(sleep_in),
		.idle_mode_in(idle_mode_in), .power_down_in(power_down_in),
		.wdt_tick_in(strobe_r[0]), .startup_done_in(strobe_r[1]),
		.wake_out(wake_out), .io_clk_run_out(io_clk_run_out));

	// Bus, pulse and compare helpers
	task chk(input [8*12:1] what, input [7:0] seen, input [7:0] exp);
		begin
			total_checks = total_checks + 1;
			if (seen !== exp) begin
				failures = failures + 1;
				$display("FAIL %0s expected %h seen %h", what, exp, seen);
			end
		end
	endtask
	task wr(input [2:0] a, input [7:0] d);
		begin
			@(posedge mclk_in);
			reg_wr_in <= 1'b1;
			reg_addr_in <= a;
			reg_wdata_in <= d;
			@(posedge mclk_in);
			reg_wr_in <= 1'b0;
		end
	endtask
	task rd(input [2:0] a, input [7:0] exp, input [8*12:1] what);
		begin
			@(posedge mclk_in);
			reg_rd_in <= 1'b1;
			reg_addr_in <= a;
			@(posedge mclk_in);
			reg_rd_in <= 1'b0;
			#1 chk(what, reg_rdata_out, exp);
		end
	endtask
	task ack(input [4:0] m);
		begin
			@(posedge mclk_in);
			irq_ack_in <= m;
			@(posedge mclk_in);
			irq_ack_in <= 5'h00;
		end
	endtask
	task strobe(input [1:0] s);
		begin
			@(posedge mclk_in);
			strobe_r <= s;
			@(posedge mclk_in);
			strobe_r <= 2'h0;
		end
	endtask
	task cyc(input integer n);
		begin
			repeat (n) @(posedge mclk_in);
			#1;
		end
	endtask
	task final_report;
		begin
			$display("checks %0d mismatches %0d", total_checks, failures);
			if (failures == 0 && total_checks > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask

	// Hang guard
	always @(posedge mclk_in) begin
		cycles = cycles + 1;
		if (cycles == 4000) begin
			failures = failures + 1;
			final_report;
		end
	end

	// Test sequence
	initial begin
		repeat (8) @(posedge mclk_in);
		rst_b_in <= 1'b1;
		for (c = 0; c < 6; c = c + 1)
			rd(c[2:0], 8'h00, "reset value");
		wr(3'h7, 8'hFF);
		rd(3'h7, 8'h00, "unmapped");
		wr(`EIU_OFS_PIN_STATE, 8'h00);
		rd(`EIU_OFS_PIN_STATE, 8'h07, "pin state");
		$display("test registers done");
		for (l = 0; l < 2; l = l + 1)
			for (c = 1; c < 4; c = c + 1) begin
				en = l ? 8'h80 : 8'h40;
				wr(`EIU_OFS_MCU_CTRL, c[7:0] << (2 * l));
				wr(`EIU_OFS_ENABLE, en);
				wr(`EIU_OFS_FLAGS, 8'hFF);
				u_eiu_pins_model.drive_line(l, 1'b0, 2);
				cyc(4);
				rd(`EIU_OFS_FLAGS, (c != 3) ? en : 8'h00, "fall flag");
				chk("fall req", {3'h0, irq_req_out}, (c != 3) ? 8'h01 << l : 8'h00);
				wr(`EIU_OFS_FLAGS, 8'hFF);
				u_eiu_pins_model.drive_line(l, 1'b1, 2);
				cyc(4);
				rd(`EIU_OFS_FLAGS, (c != 2) ? en : 8'h00, "rise flag");
				ack(5'h01 << l);
				rd(`EIU_OFS_FLAGS, 8'h00, "ack clear");
			end
		wr(`EIU_OFS_MCU_CTRL, 8'h00);
		wr(`EIU_OFS_ENABLE, 8'h40);
		u_eiu_pins_model.drive_line(0, 1'b0, 8);
		chk("level req", {3'h0, irq_req_out}, 8'h01);
		ack(5'h01);
		rd(`EIU_OFS_FLAGS, 8'h00, "level flag");
		chk("level hold", {3'h0, irq_req_out}, 8'h01);
		u_eiu_pins_model.drive_line(0, 1'b1, 4);
		chk("level off", {3'h0, irq_req_out}, 8'h00);
		$display("test lines zero and one done");
		for (c = 0; c < 2; c = c + 1) begin
			wr(`EIU_OFS_EXT_CTRL, c[7:0]);
			rd(`EIU_OFS_EXT_CTRL, c[7:0], "edge select");
			wr(`EIU_OFS_ENABLE, 8'h20);
			wr(`EIU_OFS_FLAGS, 8'hFF);
			u_eiu_pins_model.drive_line(2, 1'b0, 2);
			cyc(4);
			rd(`EIU_OFS_FLAGS, c ? 8'h00 : 8'h20, "l2 fall");
			ack(5'h04);
			u_eiu_pins_model.drive_line(2, 1'b1, 2);
			cyc(4);
			rd(`EIU_OFS_FLAGS, c ? 8'h20 : 8'h00, "l2 rise");
			chk("l2 req", {3'h0, irq_req_out}, c ? 8'h04 : 8'h00);
			ack(5'h04);
			rd(`EIU_OFS_FLAGS, 8'h00, "l2 ack");
		end
		$display("test line two done");
		wr(`EIU_OFS_MASK_LO, 8'h01);
		wr(`EIU_OFS_MASK_HI, 8'h80);
		wr(`EIU_OFS_ENABLE, 8'h18);
		rd(`EIU_OFS_MASK_HI, 8'h80, "mask high");
		rd(`EIU_OFS_ENABLE, 8'h18, "enable");
		wr(`EIU_OFS_FLAGS, 8'hFF);
		u_eiu_pins_model.toggle_pc(1, 2);
		u_eiu_pins_model.toggle_pc(14, 2);
		cyc(4);
		rd(`EIU_OFS_FLAGS, 8'h00, "masked");
		for (c = 0; c < 2; c = c + 1) begin
			u_eiu_pins_model.toggle_pc(0, 2);
			cyc(4);
			rd(`EIU_OFS_FLAGS, 8'h08, "pc low");
			u_eiu_pins_model.toggle_pc(15, 2);
			cyc(4);
			rd(`EIU_OFS_FLAGS, 8'h18, "pc high");
			chk("pc req", {3'h0, irq_req_out}, 8'h18);
			ack(5'h18);
			cyc(1);
			chk("pc ack", {3'h0, irq_req_out}, 8'h00);
		end
		$display("test pin change done");
		wr(`EIU_OFS_MCU_CTRL, 8'h02);
		rd(`EIU_OFS_MCU_CTRL, 8'h02, "sense ctrl");
		wr(`EIU_OFS_EXT_CTRL, 8'h00);
		wr(`EIU_OFS_ENABLE, 8'h60);
		wr(`EIU_OFS_FLAGS, 8'hFF);
		@(posedge mclk_in);
		sleep_in <= 1'b1;
		u_eiu_pins_model.drive_line(0, 1'b0, 2);
		cyc(4);
		chk("io clk", {7'h00, io_clk_run_out}, 8'h00);
		rd(`EIU_OFS_FLAGS, 8'h00, "stopped edge");
		chk("no wake", {7'h00, wake_out}, 8'h00);
		u_eiu_pins_model.drive_line(2, 1'b0, 2);
		cyc(4);
		chk("l2 wake", {7'h00, wake_out}, 8'h01);
		wr(`EIU_OFS_FLAGS, 8'hFF);
		@(posedge mclk_in);
		idle_mode_in <= 1'b1;
		u_eiu_pins_model.drive_line(0, 1'b1, 2);
		u_eiu_pins_model.drive_line(0, 1'b0, 2);
		cyc(4);
		rd(`EIU_OFS_FLAGS, 8'h40, "idle edge");
		chk("idle wake", {7'h00, wake_out}, 8'h01);
		@(posedge mclk_in);
		sleep_in <= 1'b0;
		idle_mode_in <= 1'b0;
		u_eiu_pins_model.drive_line(0, 1'b1, 2);
		u_eiu_pins_model.drive_line(2, 1'b1, 2);
		$display("test sleep done");
		wr(`EIU_OFS_MCU_CTRL, 8'h00);
		wr(`EIU_OFS_ENABLE, 8'h40);
		wr(`EIU_OFS_FLAGS, 8'hFF);
		for (v = 0; v < 2; v = v + 1) begin
			@(posedge mclk_in);
			sleep_in <= 1'b1;
			power_down_in <= 1'b1;
			u_eiu_pins_model.drive_line(0, 1'b0, 4);
			chk("pd early", {7'h00, wake_out}, 8'h00);
			strobe(2'h1);
			cyc(2);
			chk("pd one", {7'h00, wake_out}, 8'h00);
			strobe(2'h1);
			cyc(2);
			chk("pd wake", {7'h00, wake_out}, 8'h01);
			if (v)
				u_eiu_pins_model.drive_line(0, 1'b1, 4);
			chk("pd hold", {7'h00, wake_out}, 8'h01);
			strobe(2'h2);
			cyc(1);
			chk("pd req", {3'h0, irq_req_out}, v ? 8'h00 : 8'h01);
			u_eiu_pins_model.drive_line(0, 1'b1, 4);
			@(posedge mclk_in);
			sleep_in <= 1'b0;
			power_down_in <= 1'b0;
		end
		$display("test power-down done");
		@(posedge mclk_in);
		rst_b_in <= 1'b0;
		repeat (2) @(posedge mclk_in);
		rst_b_in <= 1'b1;
		wr(`EIU_OFS_MCU_CTRL, 8'h03);
		cyc(4);
		rd(`EIU_OFS_FLAGS, 8'h00, "reset edge");
		$display("test mid-run reset done");
		final_report;
	end
endmodule // eiu_top_tb
